// >>> design/apsc_seq.sv
// Power-state, reset and self-calibration sequencer of a delta-sigma ADC.
// Assumes a 25 MHz clock, inputs synchronous to it, and a host on a plain register port.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module apsc_seq #(
  parameter int unsigned SLEEP_SLOW_CYC = apsc_pkg::CYC_SLEEP_SLOW,
  parameter int unsigned RST_SLOW_CYC   = apsc_pkg::CYC_RST_SLOW,
  parameter int unsigned BOOT_CYC       = apsc_pkg::CYC_BOOT,
  parameter int unsigned CAL_CYC        = apsc_pkg::CYC_CAL,
  parameter int unsigned WAKE_SLEEP_CYC = 25000,
  parameter int unsigned WAKE_STBY_CYC  = 250
) (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   clk_en,
  input  wire logic                   hw_reset_n_pin,
  input  wire apsc_pkg::apsc_bus_req_t bus_req,
  output logic [31:0]                 bus_rdata,
  output logic [1:0]                  power_state_status,
  output apsc_pkg::apsc_analog_t      analog_ctl
);

  apsc_pkg::apsc_st_t st_reg;
  apsc_pkg::apsc_st_t st_next;

  // Half of each calibration time is spent per phase.
  localparam int unsigned CAL_HALF = (CAL_CYC / 2 < 1) ? 1 : CAL_CYC / 2;

  function automatic logic [31:0] cyc32(input int unsigned n);
    return 32'(n);
  endfunction : cyc32

  // Every register write strobe goes through this one decoder, so a store and its side effects agree.
  function automatic logic wr_hit(input apsc_pkg::apsc_bus_req_t req, input logic [7:0] a);
    return req.wr && req.addr == a;
  endfunction : wr_hit

  function automatic apsc_pkg::apsc_st_t defaults(input logic keep_boot);
    apsc_pkg::apsc_st_t d;
    d           = '0;
    d.state     = keep_boot ? apsc_pkg::APSC_BOOT : apsc_pkg::APSC_STANDBY;
    d.target    = apsc_pkg::APSC_STANDBY;
    d.cal_phase = apsc_pkg::APSC_CAL_NONE;
    d.pd_sel    = apsc_pkg::CONTROL_ONE_REG_RST[1:0];
    d.cal_sel   = apsc_pkg::CONTROL_ONE_REG_RST[3:2];
    d.seq_mode  = apsc_pkg::SEQ_RST;
    d.ps_status = apsc_pkg::PS_STANDBY;
    d.filt_clr  = 1'b1;
    return d;
  endfunction : defaults

  logic wr_ctrl;
  logic wr_cmd;
  logic [1:0] cmd_mode;
  logic busy;

  always_comb
  begin
    wr_ctrl  = wr_hit(bus_req, apsc_pkg::ADDR_CONTROL_ONE_REG) || wr_hit(bus_req, apsc_pkg::ADDR_SEQCFG);
    wr_cmd   = wr_hit(bus_req, apsc_pkg::ADDR_CMD);
    cmd_mode = bus_req.wdata[apsc_pkg::CMD_MODE_LSB +: 2];
    busy     = st_reg.state == apsc_pkg::APSC_CONV || st_reg.state == apsc_pkg::APSC_CAL;
  end

  always_comb
  begin
    st_next          = st_reg;
    st_next.filt_clr = 1'b0;
    st_next.rd_valid = bus_req.rd;
    if (st_reg.timer != 32'h0000_0000)
    begin
      st_next.timer = st_reg.timer - 32'h0000_0001;
    end

    // Register reads answer in the next cycle; unmapped offsets read zero.
    st_next.rdata = 32'h0000_0000;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        apsc_pkg::ADDR_CONTROL_ONE_REG:  st_next.rdata = {28'h000_0000, st_reg.cal_sel, st_reg.pd_sel};
        apsc_pkg::ADDR_SEQCFG: st_next.rdata = {30'h0000_0000, st_reg.seq_mode};
        apsc_pkg::ADDR_STATUS: st_next.rdata = {29'h0000_0000, st_reg.in_reset,
                                                st_reg.ps_status};
        default:               st_next.rdata = 32'h0000_0000;
      endcase
    end

    // Control register writes.
    if (wr_hit(bus_req, apsc_pkg::ADDR_CONTROL_ONE_REG))
    begin
      st_next.pd_sel  = bus_req.wdata[apsc_pkg::CONTROL_ONE_REG_PD_LSB +: 2];
      st_next.cal_sel = bus_req.wdata[apsc_pkg::CONTROL_ONE_REG_CAL_LSB +: 2];
    end
    if (wr_hit(bus_req, apsc_pkg::ADDR_SEQCFG))
    begin
      st_next.seq_mode = bus_req.wdata[apsc_pkg::SEQ_MODE_LSB +: 2];
    end

    unique case (st_reg.state)
      apsc_pkg::APSC_BOOT:
      begin
        st_next.in_reset = 1'b1;
        if (st_reg.timer == 32'h0000_0000)
        begin
          st_next.state     = apsc_pkg::APSC_STANDBY;
          st_next.in_reset  = 1'b0;
          st_next.ps_status = apsc_pkg::PS_STANDBY;
        end
      end

      // A pending transition: status still shows the old state until the timer ends.
      apsc_pkg::APSC_WAKE:
      begin
        if (st_reg.timer == 32'h0000_0000)
        begin
          st_next.state    = st_reg.target;
          st_next.in_reset = 1'b0;
          unique case (st_reg.target)
            apsc_pkg::APSC_SLEEP:   st_next.ps_status = apsc_pkg::PS_SLEEP;
            apsc_pkg::APSC_CONV:    st_next.ps_status = apsc_pkg::PS_ACTIVE;
            default:                st_next.ps_status = apsc_pkg::PS_STANDBY;
          endcase
        end
      end

      apsc_pkg::APSC_CAL:
      begin
        if (st_reg.timer == 32'h0000_0000)
        begin
          if (st_reg.cal_phase == apsc_pkg::APSC_CAL_OFFSET)
          begin
            st_next.cal_phase = apsc_pkg::APSC_CAL_GAIN;
            st_next.timer     = cyc32(CAL_HALF);
          end
          else
          begin
            st_next.cal_phase = apsc_pkg::APSC_CAL_NONE;
            st_next.state     = apsc_pkg::APSC_STANDBY;
            st_next.ps_status = apsc_pkg::PS_STANDBY;
          end
        end
      end

      default:
      begin
      end
    endcase

    // Command decode; a command with mode 00 does nothing here.
    if (wr_cmd && st_reg.state != apsc_pkg::APSC_BOOT && st_reg.state != apsc_pkg::APSC_WAKE)
    begin
      if (cmd_mode == apsc_pkg::MODE_CONV)
      begin
        if (st_reg.state == apsc_pkg::APSC_SLEEP || st_reg.state == apsc_pkg::APSC_STANDBY)
        begin
          st_next.state    = apsc_pkg::APSC_WAKE;
          st_next.target   = apsc_pkg::APSC_CONV;
          st_next.filt_clr = 1'b1;
          if (st_reg.state == apsc_pkg::APSC_SLEEP)
          begin
            st_next.timer = cyc32(WAKE_SLEEP_CYC + apsc_pkg::CYC_ABORT);
          end
          else
          begin
            st_next.timer = cyc32(WAKE_STBY_CYC + apsc_pkg::CYC_ABORT);
          end
        end
      end
      else if (cmd_mode == apsc_pkg::MODE_CAL)
      begin
        if (st_reg.state == apsc_pkg::APSC_STANDBY && st_reg.cal_sel == apsc_pkg::CAL_SELF)
        begin
          st_next.state     = apsc_pkg::APSC_CAL;
          st_next.cal_phase = apsc_pkg::APSC_CAL_OFFSET;
          st_next.timer     = cyc32(CAL_HALF);
          st_next.filt_clr  = 1'b1;
        end
      end
      else if (cmd_mode == apsc_pkg::MODE_PD)
      begin
        st_next.state = apsc_pkg::APSC_WAKE;
        unique case (st_reg.pd_sel)
          apsc_pkg::PD_SLEEP:
          begin
            st_next.target = apsc_pkg::APSC_SLEEP;
            if (st_reg.state == apsc_pkg::APSC_CONV && st_reg.ps_status == apsc_pkg::PS_ACTIVE)
            begin
              st_next.timer = cyc32(apsc_pkg::CYC_FAST_SLP);
            end
            else if (busy)
            begin
              st_next.timer = cyc32(apsc_pkg::CYC_ABORT);
            end
            else if (st_reg.state == apsc_pkg::APSC_STANDBY)
            begin
              st_next.timer = cyc32(SLEEP_SLOW_CYC);
            end
            else
            begin
              st_next.state = st_reg.state;
            end
          end
          apsc_pkg::PD_STANDBY:
          begin
            st_next.target = apsc_pkg::APSC_STANDBY;
            if (st_reg.state == apsc_pkg::APSC_CONV)
            begin
              st_next.timer = cyc32(apsc_pkg::CYC_FAST_WAKE);
            end
            else if (busy)
            begin
              st_next.timer = cyc32(apsc_pkg::CYC_ABORT);
            end
            else if (st_reg.state == apsc_pkg::APSC_SLEEP)
            begin
              st_next.timer = cyc32(SLEEP_SLOW_CYC);
            end
            else
            begin
              st_next.state = st_reg.state;
            end
          end
          apsc_pkg::PD_RESET:
          begin
            st_next.target = apsc_pkg::APSC_STANDBY;
            if (st_reg.state == apsc_pkg::APSC_SLEEP)
            begin
              st_next.state = st_reg.state;
            end
            else
            begin
              st_next.pd_sel    = apsc_pkg::CONTROL_ONE_REG_RST[1:0];
              st_next.cal_sel   = apsc_pkg::CONTROL_ONE_REG_RST[3:2];
              st_next.seq_mode  = apsc_pkg::SEQ_RST;
              st_next.cal_phase = apsc_pkg::APSC_CAL_NONE;
              st_next.in_reset  = 1'b1;
              st_next.filt_clr  = 1'b1;
              st_next.timer     = busy ? cyc32(apsc_pkg::CYC_RST_ABORT)
                                       : cyc32(RST_SLOW_CYC);
            end
          end
          default:
          begin
            st_next.state = st_reg.state;
          end
        endcase
        // Leaving calibration early must also open the input switches; otherwise the
        // inputs would stay shorted or on the reference through the following state.
        if (busy && st_next.state == apsc_pkg::APSC_WAKE)
        begin
          st_next.cal_phase = apsc_pkg::APSC_CAL_NONE;
        end
      end
    end

    // A control write during activity aborts it to standby.
    if (wr_ctrl && busy)
    begin
      st_next.state     = apsc_pkg::APSC_STANDBY;
      st_next.cal_phase = apsc_pkg::APSC_CAL_NONE;
      st_next.ps_status = apsc_pkg::PS_STANDBY;
      st_next.filt_clr  = 1'b1;
    end

    // Software reset: registers and state machines only, no boot delay.
    if (wr_hit(bus_req, apsc_pkg::ADDR_SWRST))
    begin
      st_next = defaults(1'b0);
    end

    // Pin reset takes priority and replays the full boot wait.
    if (!hw_reset_n_pin)
    begin
      st_next          = defaults(1'b1);
      st_next.timer    = cyc32(BOOT_CYC);
      st_next.in_reset = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_reg          <= '0;
      st_reg.state    <= apsc_pkg::APSC_BOOT;
      st_reg.target   <= apsc_pkg::APSC_STANDBY;
      st_reg.timer    <= cyc32(BOOT_CYC);
      st_reg.in_reset <= 1'b1;
      st_reg.filt_clr <= 1'b1;
      st_reg.ps_status <= apsc_pkg::PS_STANDBY;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  always_comb
  begin
    bus_rdata                     = st_reg.rdata;
    power_state_status            = st_reg.ps_status;
    analog_ctl                    = '0;
    analog_ctl.running            = st_reg.state == apsc_pkg::APSC_CONV;
    analog_ctl.cal_running        = st_reg.state == apsc_pkg::APSC_CAL;
    analog_ctl.inputs_shorted     = st_reg.cal_phase == apsc_pkg::APSC_CAL_OFFSET;
    analog_ctl.inputs_to_ref      = st_reg.cal_phase == apsc_pkg::APSC_CAL_GAIN;
    analog_ctl.filter_clear       = st_reg.filt_clr;
    analog_ctl.pga_bypass         = st_reg.state == apsc_pkg::APSC_CAL;
  end

endmodule : apsc_seq

`default_nettype wire

// >>> design/apsc_pkg.sv
// Package for the ADC power-state and calibration sequencer.
// Assumes a 25 MHz system clock; all times except the wake times from sleep and from standby are turned into cycle counts here.
package apsc_pkg;

  localparam int unsigned CLK_HZ = 25000000;

  // Register map of the plain register port, byte offsets.
  localparam logic [7:0] ADDR_CONTROL_ONE_REG   = 8'h00;
  localparam logic [7:0] ADDR_SEQCFG  = 8'h04;
  localparam logic [7:0] ADDR_CMD     = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_SWRST   = 8'h10;

  // Field positions.
  localparam int unsigned CONTROL_ONE_REG_PD_LSB  = 0;
  localparam int unsigned CONTROL_ONE_REG_CAL_LSB = 2;
  localparam int unsigned SEQ_MODE_LSB  = 0;
  localparam int unsigned CMD_MODE_LSB  = 0;

  // Reset values.
  localparam logic [3:0] CONTROL_ONE_REG_RST = 4'h0;
  localparam logic [1:0] SEQ_RST   = 2'h0;

  // Power-down select codes and command mode codes.
  localparam logic [1:0] PD_SLEEP   = 2'h1;
  localparam logic [1:0] PD_STANDBY = 2'h2;
  localparam logic [1:0] PD_RESET   = 2'h3;
  localparam logic [1:0] MODE_PD    = 2'h1;
  localparam logic [1:0] MODE_CAL   = 2'h2;
  localparam logic [1:0] MODE_CONV  = 2'h3;
  localparam logic [1:0] CAL_SELF   = 2'h0;
  localparam logic [1:0] SEQ_MODE1  = 2'h0;

  // Power state status codes.
  localparam logic [1:0] PS_ACTIVE  = 2'h0;
  localparam logic [1:0] PS_SLEEP   = 2'h1;
  localparam logic [1:0] PS_STANDBY = 2'h2;

  // Transition times in nanoseconds, as printed, and derived cycle counts (rounded down).
  localparam longint unsigned T_SLEEP_SLOW_NS = 64'd20000000;
  localparam longint unsigned T_ABORT_NS      = 64'd3000;
  localparam longint unsigned T_RST_SLOW_NS   = 64'd28000000;
  localparam longint unsigned T_RST_ABORT_NS  = 64'd6000;
  localparam longint unsigned T_BOOT_NS       = 64'd10000000;
  localparam longint unsigned T_FAST_WAKE_NS  = 64'd85000;
  localparam longint unsigned T_FAST_SLP_NS   = 64'd15000;
  localparam longint unsigned T_CAL_NS        = 64'd200000000;

  function automatic int unsigned ns_to_cyc(input longint unsigned ns);
    longint unsigned c;
    c = (ns * CLK_HZ) / 64'd1000000000;
    return (c < 64'd1) ? 32'd1 : 32'(c);
  endfunction : ns_to_cyc

  localparam int unsigned CYC_SLEEP_SLOW = ns_to_cyc(T_SLEEP_SLOW_NS);
  localparam int unsigned CYC_ABORT      = ns_to_cyc(T_ABORT_NS);
  localparam int unsigned CYC_RST_SLOW   = ns_to_cyc(T_RST_SLOW_NS);
  localparam int unsigned CYC_RST_ABORT  = ns_to_cyc(T_RST_ABORT_NS);
  localparam int unsigned CYC_BOOT       = ns_to_cyc(T_BOOT_NS);
  localparam int unsigned CYC_FAST_WAKE  = ns_to_cyc(T_FAST_WAKE_NS);
  localparam int unsigned CYC_FAST_SLP   = ns_to_cyc(T_FAST_SLP_NS);
  localparam int unsigned CYC_CAL        = ns_to_cyc(T_CAL_NS);

  typedef enum logic [2:0] {
    APSC_BOOT    = 3'b000,
    APSC_STANDBY = 3'b001,
    APSC_SLEEP   = 3'b010,
    APSC_WAKE    = 3'b011,
    APSC_CONV    = 3'b100,
    APSC_CAL     = 3'b101,
    APSC_GO      = 3'b110
  } apsc_state_t;

  typedef enum logic [1:0] {
    APSC_CAL_NONE   = 2'b00,
    APSC_CAL_OFFSET = 2'b01,
    APSC_CAL_GAIN   = 2'b10
  } apsc_calph_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } apsc_bus_req_t;

  typedef struct packed {
    logic        running;
    logic        cal_running;
    logic        inputs_shorted;
    logic        inputs_to_ref;
    logic        filter_clear;
    logic        pga_bypass;
  } apsc_analog_t;

  typedef struct packed {
    apsc_state_t state;
    apsc_state_t target;
    apsc_calph_t cal_phase;
    logic [31:0] timer;
    logic [1:0]  pd_sel;
    logic [1:0]  cal_sel;
    logic [1:0]  seq_mode;
    logic [1:0]  ps_status;
    logic        in_reset;
    logic        filt_clr;
    logic        rd_valid;
    logic [31:0] rdata;
  } apsc_st_t;

endpackage : apsc_pkg

// >>> tb/apsc_seq_asserts.sv
// Checker for the power sequencer, watching only the top-level ports.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module apsc_seq_asserts (
  input wire logic                    clk,
  input wire logic                    rst_b,
  input wire logic                    clk_en,
  input wire logic                    hw_reset_n_pin,
  input wire apsc_pkg::apsc_bus_req_t bus_req,
  input wire logic [31:0]             bus_rdata,
  input wire logic [1:0]              power_state_status,
  input wire apsc_pkg::apsc_analog_t  analog_ctl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_PIN_STOP: assert property (
    !hw_reset_n_pin && clk_en |=> !analog_ctl.running && !analog_ctl.cal_running)
    else $error("pin reset left activity running");
  AST_PIN_STBY: assert property (
    !hw_reset_n_pin && clk_en |=> analog_ctl.filter_clear && power_state_status == 2'h2)
    else $error("pin reset did not clear filter or show standby");
  AST_BOOT_STS: assert property ($rose(rst_b) |-> power_state_status == 2'h2)
    else $error("status not standby after reset");
  AST_RUN_ACT: assert property (analog_ctl.running |-> power_state_status == 2'h0)
    else $error("running without active status");
  AST_CAL_STS: assert property (analog_ctl.cal_running |-> power_state_status == 2'h2)
    else $error("status moved during calibration");
  AST_CAL_PGA: assert property (analog_ctl.cal_running |-> analog_ctl.pga_bypass)
    else $error("amplifier included in calibration");
  AST_CAL_ORDER: assert property (
    $rose(analog_ctl.inputs_to_ref) |-> $past(analog_ctl.inputs_shorted))
    else $error("gain phase without offset phase");
  AST_CAL_IDLE: assert property (
    !analog_ctl.cal_running |-> !analog_ctl.inputs_shorted && !analog_ctl.inputs_to_ref)
    else $error("calibration switches closed outside calibration");
  AST_CAL_EXCL: assert property (
    !(analog_ctl.inputs_shorted && analog_ctl.inputs_to_ref))
    else $error("inputs shorted and on reference together");
  AST_RD_STS: assert property (
    bus_req.rd && clk_en && hw_reset_n_pin && bus_req.addr == 8'h0C
    |=> bus_rdata[1:0] == $past(power_state_status))
    else $error("status read does not match status port");
  COV_GAIN: cover property ($rose(analog_ctl.inputs_to_ref));
  COV_RUN: cover property ($rose(analog_ctl.running));
  COV_SLEEP: cover property (power_state_status == 2'h1);
endmodule : apsc_seq_asserts
`default_nettype wire

// >>> tb/apsc_host.sv
// Host model on the register port: single-cycle strobes and status polling.
// Assumes the sequencer answers reads one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module apsc_host (
  input  wire logic                    clk,
  input  wire logic [31:0]             bus_rdata,
  output var  apsc_pkg::apsc_bus_req_t bus_req
);
  initial bus_req = '0;
  // Released lines carry the inverse so stale values cannot pass for a match.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '{addr: ~a, wdata: ~v, wr: 1'b0, rd: 1'b0};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '{addr: ~a, wdata: 32'hFFFFFFFF, wr: 1'b0, rd: 1'b0};
    #1 v = bus_rdata;
  endtask : rd
  // Polls the status word; the host sends nothing else meanwhile.
  task automatic poll(input logic [31:0] s, input int unsigned lim, output bit ok);
    logic [31:0] v;
    ok = 1'b0;
    for (int unsigned i = 0; i < lim && !ok; i += 2)
    begin
      rd(apsc_pkg::ADDR_STATUS, v);
      ok = (v === s);
    end
  endtask : poll
endmodule : apsc_host
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the power sequencer with shortened counts.
// Assumes the host model and the checker from the other bench files.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned BOOT = 40;
  localparam int unsigned SLOW = 30;
  localparam int unsigned CAL  = 40;
  localparam int unsigned WSLP = 20;
  localparam int unsigned WSBY = 5;
  logic                    clk;
  logic                    rst_b;
  logic                    hw_reset_n_pin;
  logic                    clk_en;
  apsc_pkg::apsc_bus_req_t bus_req;
  logic [31:0]             bus_rdata;
  logic [1:0]              pss;
  apsc_pkg::apsc_analog_t  actl;
  wire logic [3:0]         cv;
  int                      errors;
  int                      n_tests;
  int                      cyc;
  logic [31:0]             d;
  assign cv = {actl.cal_running, actl.inputs_shorted, actl.pga_bypass, actl.inputs_to_ref};
  apsc_seq #(.SLEEP_SLOW_CYC(SLOW), .RST_SLOW_CYC(SLOW), .BOOT_CYC(BOOT), .CAL_CYC(CAL),
    .WAKE_SLEEP_CYC(WSLP), .WAKE_STBY_CYC(WSBY)) i_apsc_seq (.clk(clk), .rst_b(rst_b),
    .clk_en(clk_en), .hw_reset_n_pin(hw_reset_n_pin), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .power_state_status(pss), .analog_ctl(actl));
  apsc_host i_apsc_host (.clk(clk), .bus_rdata(bus_rdata), .bus_req(bus_req));
  initial clk = 1'b0;
  always #20 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input logic [7:0] a, input logic [31:0] v);
    i_apsc_host.wr(a, v);
  endtask : w
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    i_apsc_host.rd(a, d);
    chk(d, exp);
  endtask : rc
  task automatic pc(input logic [31:0] s, input int unsigned lim);
    bit ok;
    i_apsc_host.poll(s, lim, ok);
    chk({31'h0, ok}, 32'h1);
  endtask : pc
  task automatic wa(input logic [3:0] exp, input int unsigned lim);
    for (int unsigned i = 0; i < lim && cv !== exp; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk({28'h0, cv}, {28'h0, exp});
  endtask : wa
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      $display("MISMATCH t=%0t run did not finish", $time);
      summarize();
    end
  end
  initial
  begin
    rst_b = 1'b0;
    hw_reset_n_pin = 1'b1;
    clk_en = 1'b1;
    errors = 0;
    n_tests = 0;
    cyc = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rc(apsc_pkg::ADDR_STATUS, 32'h6);
    pc(32'h2, BOOT + 8);
    chk({31'h0, actl.running}, 32'h0);
    rc(apsc_pkg::ADDR_CONTROL_ONE_REG, 32'h0);
    rc(apsc_pkg::ADDR_SEQCFG, 32'h0);
    rc(8'h20, 32'h0);
    $display("test boot done");
    w(apsc_pkg::ADDR_CMD, 32'h3);
    rc(apsc_pkg::ADDR_STATUS, 32'h2);
    pc(32'h0, WSBY + 83);
    chk({31'h0, actl.running}, 32'h1);
    w(apsc_pkg::ADDR_CONTROL_ONE_REG, 32'h1);
    pc(32'h2, 8);
    chk({31'h0, actl.running}, 32'h0);
    rc(apsc_pkg::ADDR_CONTROL_ONE_REG, 32'h1);
    $display("test convert and abort done");
    w(apsc_pkg::ADDR_CMD, 32'h1);
    rc(apsc_pkg::ADDR_STATUS, 32'h2);
    pc(32'h1, SLOW + 8);
    w(apsc_pkg::ADDR_CMD, 32'h1);
    repeat (10) @(posedge clk);
    rc(apsc_pkg::ADDR_STATUS, 32'h1);
    w(apsc_pkg::ADDR_CMD, 32'h3);
    pc(32'h0, WSLP + 83);
    w(apsc_pkg::ADDR_CMD, 32'h1);
    pc(32'h1, 383);
    $display("test sleep done");
    w(apsc_pkg::ADDR_CONTROL_ONE_REG, 32'h2);
    w(apsc_pkg::ADDR_SEQCFG, 32'h0);
    w(apsc_pkg::ADDR_CMD, 32'h3);
    pc(32'h0, WSLP + 83);
    w(apsc_pkg::ADDR_CMD, 32'h1);
    pc(32'h2, 2133);
    $display("test fast standby done");
    w(apsc_pkg::ADDR_SEQCFG, 32'h1);
    w(apsc_pkg::ADDR_CONTROL_ONE_REG, 32'h3);
    w(apsc_pkg::ADDR_CMD, 32'h1);
    repeat (SLOW + 8) @(posedge clk);
    rc(apsc_pkg::ADDR_CONTROL_ONE_REG, 32'h0);
    rc(apsc_pkg::ADDR_SEQCFG, 32'h0);
    rc(apsc_pkg::ADDR_STATUS, 32'h2);
    $display("test reset command done");
    w(apsc_pkg::ADDR_CMD, 32'h2);
    wa(4'hE, 8);
    wa(4'hB, CAL);
    wa(4'h0, CAL);
    rc(apsc_pkg::ADDR_STATUS, 32'h2);
    $display("test calibration done");
    w(apsc_pkg::ADDR_CONTROL_ONE_REG, 32'h1);
    w(apsc_pkg::ADDR_CMD, 32'h2);
    wa(4'hE, 8);
    w(apsc_pkg::ADDR_CMD, 32'h1);
    pc(32'h1, 83);
    chk({28'h0, cv}, 32'h0);
    $display("test sleep during calibration done");
    w(apsc_pkg::ADDR_CONTROL_ONE_REG, 32'h1);
    w(apsc_pkg::ADDR_SEQCFG, 32'h1);
    w(apsc_pkg::ADDR_SWRST, 32'h1);
    rc(apsc_pkg::ADDR_CONTROL_ONE_REG, 32'h0);
    rc(apsc_pkg::ADDR_SEQCFG, 32'h0);
    pc(32'h2, BOOT + 8);
    $display("test software reset done");
    @(posedge clk);
    clk_en <= 1'b0;
    w(apsc_pkg::ADDR_CONTROL_ONE_REG, 32'h2);
    clk_en <= 1'b1;
    rc(apsc_pkg::ADDR_CONTROL_ONE_REG, 32'h0);
    w(apsc_pkg::ADDR_CONTROL_ONE_REG, 32'h3);
    w(apsc_pkg::ADDR_CMD, 32'h3);
    pc(32'h0, WSBY + 83);
    w(apsc_pkg::ADDR_CMD, 32'h1);
    pc(32'h2, 158);
    rc(apsc_pkg::ADDR_CONTROL_ONE_REG, 32'h0);
    $display("test freeze and reset abort done");
    w(apsc_pkg::ADDR_CONTROL_ONE_REG, 32'h1);
    w(apsc_pkg::ADDR_CMD, 32'h3);
    pc(32'h0, WSBY + 83);
    @(posedge clk);
    hw_reset_n_pin <= 1'b0;
    repeat (2) @(posedge clk);
    hw_reset_n_pin <= 1'b1;
    #1 chk({31'h0, actl.running}, 32'h0);
    rc(apsc_pkg::ADDR_STATUS, 32'h6);
    pc(32'h2, BOOT + 8);
    rc(apsc_pkg::ADDR_CONTROL_ONE_REG, 32'h0);
    $display("test pin reset done");
    summarize();
  end
endmodule : testbench
bind apsc_seq apsc_seq_asserts i_apsc_seq_asserts (.clk(clk), .rst_b(rst_b),
  .clk_en(clk_en), .hw_reset_n_pin(hw_reset_n_pin), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .power_state_status(power_state_status), .analog_ctl(analog_ctl));
`default_nettype wire
